// *** rtl/orc_pkg.sv ***
package orc_pkg;
	// Register byte offsets from the function's memory base
	localparam logic [7:0] REVISION_OFS = 8'h00;
	localparam logic [7:0] CONTROL_OFS = 8'h04;
	// Revision fields
	localparam logic [7:0] REVISION_CODE = 8'h10;
	localparam int REV_LO = 0;
	localparam int LEGACY_BIT = 8;
	// Control register fields
	localparam int RATIO_LO = 0;
	localparam int PERIODIC_BIT = 2;
	localparam int ISO_BIT = 3;
	localparam int CTRL_LIST_BIT = 4;
	localparam int BULK_BIT = 5;
	localparam int FSTATE_LO = 6;
	localparam int ROUTING_BIT = 8;
	localparam int CONNECTED_BIT = 9;
	localparam int WAKE_EN_BIT = 10;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	// Functional state encodings
	localparam logic [1:0] FS_RESET = 2'h0;
	localparam logic [1:0] FS_RESUME = 2'h1;
	localparam logic [1:0] FS_OPERATIONAL = 2'h2;
	localparam logic [1:0] FS_SUSPEND = 2'h3;

	// Register access request from the host bus side
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [31:0] wdata;
	} orc_req_s;

	// Driver-visible control fields
	typedef struct packed {
		logic wakeEnable;
		logic wakeConnected;
		logic irqRoutingSelect;
		logic [1:0] functionalState;
		logic bulkListEn;
		logic ctrlListEn;
		logic isoEn;
		logic periodicListEn;
		logic [1:0] ctrlBulkRatio;
	} orc_ctl_s;
endpackage

// *** rtl/orc_wake_detect.sv ***
`timescale 1ns/10ps
// Registered wake request: enable and resume-detected both set
module orc_wake_detect (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic wakeEnable,
	input wire logic resumeDetected,
	output logic wakeRequest
);
	logic wake_q;
	logic wake_d;

	// Combine the two conditions; interrupts are not involved here
	always_comb begin
		wake_d = wakeEnable & resumeDetected;
	end

	// Register so the top output comes from a flip-flop
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wake_q <= 1'h0;
		end else begin
			wake_q <= wake_d;
		end
	end

	assign wakeRequest = wake_q;
endmodule

// *** rtl/orc_regs.sv ***
`timescale 1ns/10ps
module orc_regs #(
	parameter bit FIRST_FUNCTION = 1'b1
) (
	input wire logic clock,
	input wire logic rst_n,
	input orc_pkg::orc_req_s req,
	input wire logic resumeDetected,
	input wire logic hwStateWrite,
	input wire logic [1:0] hwState,
	input wire logic hwConnectedWrite,
	input wire logic hwConnected,
	input wire logic irqEventIn,
	output logic [31:0] rdata,
	output logic rdValid,
	output orc_pkg::orc_ctl_s ctl,
	output logic irqNormal,
	output logic irqManagement,
	output logic wakeRequest
);
	orc_pkg::orc_ctl_s ctl_q;
	orc_pkg::orc_ctl_s ctl_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic rdValid_q;
	logic rdValid_d;
	logic irqNormal_q;
	logic irqNormal_d;
	logic irqMgmt_q;
	logic irqMgmt_d;

	// Offset decode used by both the read and write paths
	function automatic logic hitsReg(input logic [7:0] a,
		input logic [7:0] ofs);
		hitsReg = (a == ofs);
	endfunction

	// Pack control fields into their 32-bit image
	function automatic logic [31:0] ctlImage(input orc_pkg::orc_ctl_s c);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[orc_pkg::RATIO_LO +: 2] = c.ctrlBulkRatio;
		v[orc_pkg::PERIODIC_BIT] = c.periodicListEn;
		v[orc_pkg::ISO_BIT] = c.isoEn;
		v[orc_pkg::CTRL_LIST_BIT] = c.ctrlListEn;
		v[orc_pkg::BULK_BIT] = c.bulkListEn;
		v[orc_pkg::FSTATE_LO +: 2] = c.functionalState;
		v[orc_pkg::ROUTING_BIT] = c.irqRoutingSelect;
		v[orc_pkg::CONNECTED_BIT] = c.wakeConnected;
		v[orc_pkg::WAKE_EN_BIT] = c.wakeEnable;
		ctlImage = v;
	endfunction

	// Control register: driver writes, then the two hardware-owned fields
	always_comb begin
		ctl_d = ctl_q;
		if (req.wr && hitsReg(req.addr, orc_pkg::CONTROL_OFS)) begin
			// Reserved bits 31:11 are expected zero and are not stored
			ctl_d.ctrlBulkRatio = req.wdata[orc_pkg::RATIO_LO +: 2];
			ctl_d.periodicListEn = req.wdata[orc_pkg::PERIODIC_BIT];
			ctl_d.isoEn = req.wdata[orc_pkg::ISO_BIT];
			ctl_d.ctrlListEn = req.wdata[orc_pkg::CTRL_LIST_BIT];
			ctl_d.bulkListEn = req.wdata[orc_pkg::BULK_BIT];
			ctl_d.functionalState = req.wdata[orc_pkg::FSTATE_LO +: 2];
			ctl_d.irqRoutingSelect = req.wdata[orc_pkg::ROUTING_BIT];
			ctl_d.wakeConnected = req.wdata[orc_pkg::CONNECTED_BIT];
			ctl_d.wakeEnable = req.wdata[orc_pkg::WAKE_EN_BIT];
		end
		// Hardware updates win over a same-cycle driver write
		if (hwStateWrite) begin
			ctl_d.functionalState = hwState;
		end
		if (hwConnectedWrite) begin
			ctl_d.wakeConnected = hwConnected;
		end
	end

	// Read path: one cycle after the strobe; writes to revision dropped
	always_comb begin
		rdata_d = 32'h0000_0000;
		rdValid_d = req.rd;
		if (req.rd) begin
			if (hitsReg(req.addr, orc_pkg::REVISION_OFS)) begin
				// Upper bits stay zero
				rdata_d[orc_pkg::REV_LO +: 8] = orc_pkg::REVISION_CODE;
				rdata_d[orc_pkg::LEGACY_BIT] = FIRST_FUNCTION;
			end else if (hitsReg(req.addr, orc_pkg::CONTROL_OFS)) begin
				rdata_d = ctlImage(ctl_q);
			end
		end
	end

	// Interrupt steering uses routing only, never the wake enable
	always_comb begin
		irqNormal_d = irqEventIn & ~ctl_q.irqRoutingSelect;
		irqMgmt_d = irqEventIn & ctl_q.irqRoutingSelect;
	end

	// Control register state; a hardware reset puts the controller
	// back in the reset functional state with every list disabled,
	// so nothing is fetched until the driver sets the enables again
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctl_q <= orc_pkg::orc_ctl_s'(orc_pkg::CONTROL_RESET[10:0]);
		end else begin
			ctl_q <= ctl_d;
		end
	end

	// Read answer state; data is forced to zero between reads so a
	// stale word can never be mistaken for a fresh answer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
			rdValid_q <= 1'h0;
		end else begin
			rdata_q <= rdata_d;
			rdValid_q <= rdValid_d;
		end
	end

	// Interrupt steering state; the one-cycle delay keeps both
	// outputs glitch free at the cost of a cycle of latency
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irqNormal_q <= 1'h0;
			irqMgmt_q <= 1'h0;
		end else begin
			irqNormal_q <= irqNormal_d;
			irqMgmt_q <= irqMgmt_d;
		end
	end

	// Wake request generation
	orc_wake_detect wakeDet (
		.clock(clock),
		.rst_n(rst_n),
		.wakeEnable(ctl_q.wakeEnable),
		.resumeDetected(resumeDetected),
		.wakeRequest(wakeRequest)
	);

	assign rdata = rdata_q;
	assign rdValid = rdValid_q;
	assign ctl = ctl_q;
	assign irqNormal = irqNormal_q;
	assign irqManagement = irqMgmt_q;
endmodule

// *** tb/orc_regs_props.sv ***
`timescale 1ns/10ps
module orc_regs_chk #(parameter bit FIRST_FUNCTION = 1'b1) (
	input logic clock,
	input logic rst_n,
	input orc_pkg::orc_req_s req,
	input logic resumeDetected,
	input logic hwStateWrite,
	input logic [1:0] hwState,
	input logic irqEventIn,
	input logic [31:0] rdata,
	input logic rdValid,
	input orc_pkg::orc_ctl_s ctl,
	input logic irqManagement,
	input logic wakeRequest
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Gated by reset so reset-time values never count, except ctl_rst_a, which checks the reset itself
	rd_ans_a: assert property (req.rd |=> rdValid)
		else $error("read unanswered");
	rd_pulse_a: assert property (!req.rd |=> !rdValid)
		else $error("stray read valid");
	rev_word_a: assert property (req.rd && req.addr == 8'h00 |=>
		rdata == {23'h0, FIRST_FUNCTION, 8'h10}) else $error("bad rev");
	wake_wr_a: assert property (req.wr && req.addr == 8'h04 |=>
		ctl.wakeEnable == $past(req.wdata[10])) else $error("bad enable");
	state_ld_a: assert property (hwStateWrite |=>
		ctl.functionalState == $past(hwState)) else $error("bad state");
	ctl_rst_a: assert property (disable iff (1'b0) !rst_n |=>
		ctl == '0) else $error("control not cleared");
	wake_req_a: assert property ($past(rst_n) |-> wakeRequest ==
		$past(ctl.wakeEnable && resumeDetected)) else $error("bad wake");
	irq_route_a: assert property ($past(rst_n) |-> irqManagement ==
		$past(irqEventIn && ctl.irqRoutingSelect)) else $error("bad irq");
endmodule
bind orc_regs orc_regs_chk #(.FIRST_FUNCTION(FIRST_FUNCTION)) chk_i (.clock,
	.rst_n, .req, .resumeDetected, .hwStateWrite, .hwState, .irqEventIn,
	.rdata, .rdValid, .ctl, .irqManagement, .wakeRequest);

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
	logic clock = 1'b0, rst_n = 1'b0, res = 1'b0;
	logic hsw = 1'b0, irq = 1'b0, rdValid, irqM, irqN, wake;
	logic [1:0] hs = 2'h0;
	logic [31:0] rdata, d, v, x = 32'h15CEE;
	orc_pkg::orc_req_s req = '0;
	orc_pkg::orc_ctl_s ctl;
	int error_cnt = 0, tests_run = 0;
	// Clock of 10 ns period
	always #5 clock = ~clock;
	orc_regs uut (.clock, .rst_n, .req, .resumeDetected(res),
		.hwStateWrite(hsw), .hwState(hs), .hwConnectedWrite(hsw),
		.hwConnected(hs[0]), .irqEventIn(irq), .rdata, .rdValid, .ctl,
		.irqNormal(irqN), .irqManagement(irqM), .wakeRequest(wake));
	function automatic logic [31:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic chk(string n, logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic close_out();
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] wd);
		@(posedge clock);
		req <= '{!w, w, a, wd};
		@(posedge clock);
		req <= '0;
		#1 d = rdata;
		chk("valid", 32'(rdValid), 32'(!w));
	endtask
	// Reset, then the scenarios
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		bus(1'b1, 8'h00, rnd());
		bus(1'b0, 8'h00, 32'h0);
		chk("rev", d, 32'h110);
		for (int i = 0; i < 16; i++) begin
			v = i ? rnd() & 32'h7FF : 32'h7FF;
			bus(1'b1, 8'h04, v);
			bus(1'b0, 8'h04, 32'h0);
			chk("ctl", d, v);
		end
		// Wake, routing and hardware fields in all four combinations
		for (int j = 0; j < 4; j++) begin
			v = (j & 2) << 9 | (j & 1) << 8;
			bus(1'b1, 8'h04, v);
			{res, irq, hsw, hs} <= {3'h7, 2'(j)};
			repeat (2) @(posedge clock);
			#1 chk("wake", 32'(wake), j / 2);
			chk("irqm", 32'(irqM), j % 2);
			chk("irqn", 32'(irqN), 1 - j % 2);
			{res, irq, hsw} <= 3'h0;
			bus(1'b0, 8'h04, 32'h0);
			chk("hw", d, v | j << 6 | j % 2 << 9);
		end
		// Mid-run reset must clear every control field
		@(posedge clock) rst_n <= 1'b0;
		@(posedge clock) rst_n <= 1'b1;
		bus(1'b0, 8'h04, 32'h0);
		chk("rst", d, 32'h0);
		close_out();
	end
	// Watchdog against a hung run
	initial #20000 begin
		error_cnt++;
		close_out();
	end
endmodule
